// file: rtl/bss_top.sv
// Buck start-up and lockout sequencer with register port and interrupt
`timescale 1ns/1ps
`include "bss_map.svh"
module bss_top
  import bss_pkg::*;
#(
  parameter int HICCUP_CYCLES = `BSS_HICCUP_CYCLES,
  parameter int PW            = 8
) (
  input  wire logic        mclk_i,          // 50 MHz clock
  input  wire logic        rst_i,           // Async reset, high
  input  wire logic        vcc_ok_i,        // Supply above lockout
  input  wire logic        en_above_rise_i, // Enable above rising level
  input  wire logic        en_below_fall_i, // Enable below falling level
  input  wire logic        light_load_i,    // Load under half ripple
  input  wire logic        oc_event_i,      // Overcurrent sample over limit
  input  wire logic        ov_event_i,      // Output over voltage
  input  wire logic        hs_pwm_i,        // High-side request from loop
  input  wire logic        ls_pwm_i,        // Low-side request from loop
  input  wire logic [3:0]  freq_set_pin_i,  // Decoded resistor code 0..12
  input  wire logic [7:0]  addr_i,          // Register address
  input  wire logic [31:0] wdata_i,         // Write data
  input  wire logic        we_i,            // Write strobe
  input  wire logic        re_i,            // Read strobe
  output logic      [31:0] rdata_o,         // Read data, next cycle
  output logic             irq_o,           // Interrupt level
  output logic             high_side_switch_o, // High-side driver
  output logic             low_side_switch_o,  // Low-side driver
  output logic             por_o,           // Power-on-ready
  output logic             bias_high_o,     // 1 = high gate bias
  output logic      [20:0] ss_ref_o         // Soft-start reference, uV
);
  // Registers
  bss_state_t          state_q, state_d;
  logic                en_valid_q;
  logic                por_q;
  logic                run_en_q;
  logic [`BSS_EV_N-1:0] int_stat_q;
  logic [`BSS_EV_N-1:0] int_mask_q;
  logic [PW-1:0]       pos_q;
  logic [PW-1:0]       period_q;
  logic [31:0]         hic_q;
  logic                hs_q, ls_q, bias_q, irq_q;
  logic                ss_done_q;
  logic [31:0]         rdata_q;

  // Sub-block outputs
  logic [20:0]         ramp_w;
  logic [3:0]          step_w;
  logic                pb_done_w;

  // Oscillator period per resistor code; 50 MHz gives coarse steps at 1.5 MHz
  function automatic logic [PW-1:0] period_of(input logic [3:0] code);
    case (code)
      4'h0:    period_of = PW'(166);
      4'h1:    period_of = PW'(125);
      4'h2:    period_of = PW'(100);
      4'h3:    period_of = PW'(83);
      4'h4:    period_of = PW'(71);
      4'h5:    period_of = PW'(62);
      4'h6:    period_of = PW'(55);
      4'h7:    period_of = PW'(50);
      4'h8:    period_of = PW'(45);
      4'h9:    period_of = PW'(41);
      4'hA:    period_of = PW'(38);
      4'hB:    period_of = PW'(35);
      default: period_of = PW'(33);
    endcase
  endfunction : period_of

  // Lockout and readiness decode
  wire en_valid_d = en_above_rise_i ? 1'b1 :
                    (en_below_fall_i ? 1'b0 : en_valid_q);
  wire inputs_ok  = vcc_ok_i && en_valid_q && run_en_q;
  wire tick_w     = (pos_q == period_q - PW'(1));
  wire hiccup_end = (hic_q == 32'(HICCUP_CYCLES - 1));
  wire in_start_w = (ramp_w >= `BSS_START_LO_UV) && (ramp_w < `BSS_START_HI_UV);
  wire ss_done_w  = (ramp_w >= `BSS_START_HI_UV);
  wire switching  = (state_q == BSS_ST_ASYNC) || (state_q == BSS_ST_PREBIAS) ||
                    (state_q == BSS_ST_RUN);
  // Low-side window: position in period under step eighths of the period
  wire [PW+3:0] pos8_w   = {1'b0, pos_q, 3'b000};
  wire [PW+3:0] win_w    = (PW+4)'(period_q) * (PW+4)'(step_w);
  wire          ls_win_w = ((PW+4)'(pos8_w) < win_w);

  // Start-up sequence state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BSS_ST_OFF:
        if (por_q)
          state_d = BSS_ST_ASYNC;
      BSS_ST_ASYNC:
        if (hs_pwm_i)
          state_d = BSS_ST_PREBIAS;
      BSS_ST_PREBIAS:
        if (pb_done_w)
          state_d = BSS_ST_RUN;
      BSS_ST_RUN:
        state_d = BSS_ST_RUN;
      BSS_ST_HICCUP:
        if (hiccup_end)
          state_d = BSS_ST_OFF;
      default:
        state_d = BSS_ST_OFF;
    endcase
    // Protection stays live in every switching phase, soft-start included
    if (switching && oc_event_i)
      state_d = BSS_ST_HICCUP;
    if (!por_q)
      state_d = BSS_ST_OFF;
  end

  // Driver gating; overvoltage blocks the high side at once
  wire hs_d = switching && por_q && !ov_event_i && hs_pwm_i;
  wire ls_d = por_q && ls_pwm_i &&
              ((state_q == BSS_ST_RUN) ||
               ((state_q == BSS_ST_PREBIAS) && ls_win_w));

  // Interrupt events
  wire [`BSS_EV_N-1:0] ev_w;
  assign ev_w[`BSS_EV_POR]     = inputs_ok && !por_q;
  assign ev_w[`BSS_EV_LOCKOUT] = !inputs_ok && por_q;
  assign ev_w[`BSS_EV_OC]      = switching && oc_event_i;
  assign ev_w[`BSS_EV_OV]      = switching && ov_event_i;
  assign ev_w[`BSS_EV_SS_DONE] = ss_done_w && !ss_done_q;

  // Register decode
  wire sel_ctrl = (addr_i == `BSS_REG_CTRL);
  wire sel_stat = (addr_i == `BSS_REG_STATUS);
  wire sel_int  = (addr_i == `BSS_REG_INT_STAT);
  wire sel_mask = (addr_i == `BSS_REG_INT_MASK);
  wire sel_ramp = (addr_i == `BSS_REG_RAMP);
  wire sel_per  = (addr_i == `BSS_REG_PERIOD);
  wire [`BSS_EV_N-1:0] w1c_w = (we_i && sel_int) ? wdata_i[`BSS_EV_N-1:0] : '0;
  // Set wins over a same-cycle write-one clear
  wire [`BSS_EV_N-1:0] int_stat_d = (int_stat_q & ~w1c_w) | ev_w;
  wire [31:0] status_w = {16'h0000, 4'h0, step_w, 1'b0, state_q,
                          in_start_w, ss_done_q, bias_q, por_q};
  wire [31:0] rd_mux_w =
    sel_ctrl ? {31'h00000000, run_en_q} :
    sel_stat ? status_w :
    sel_int  ? {27'h0000000, int_stat_q} :
    sel_mask ? {27'h0000000, int_mask_q} :
    sel_ramp ? {11'h000, ramp_w} :
    sel_per  ? 32'(period_q) : 32'h00000000;

  // Enable hysteresis flag and power-on-ready
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      en_valid_q <= 1'b0;
      por_q      <= 1'b0;
    end
    else
    begin
      en_valid_q <= en_valid_d;
      por_q      <= inputs_ok;
    end
  end

  // Control and mask registers; clearing the run bit forces lockout
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      run_en_q   <= `BSS_CTRL_RESET;
      int_mask_q <= `BSS_MASK_RESET;
    end
    else
    begin
      if (we_i && sel_ctrl)
        run_en_q <= wdata_i[`BSS_CTRL_RUN_BIT];
      if (we_i && sel_mask)
        int_mask_q <= wdata_i[`BSS_EV_N-1:0];
    end
  end

  // Sticky status and interrupt level; the level looks at the next status
  // so that an event raises the pin one cycle sooner
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      int_stat_q <= '0;
      irq_q      <= 1'b0;
    end
    else
    begin
      int_stat_q <= int_stat_d;
      irq_q      <= |(int_stat_d & int_mask_q);
    end
  end

  // Oscillator position; period follows the resistor code each wrap
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pos_q    <= '0;
      period_q <= PW'(166);
    end
    else if (tick_w)
    begin
      pos_q    <= '0;
      period_q <= period_of(freq_set_pin_i);
    end
    else
      pos_q <= pos_q + PW'(1);
  end

  // Sequencer state
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      state_q <= BSS_ST_OFF;
    else
      state_q <= state_d;
  end

  // Hiccup timer; counts only while the state sits in hiccup, so a new
  // overcurrent waits the full blanking time unless readiness is lost, which ends hiccup early
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      hic_q <= 32'h00000000;
    else
      hic_q <= (state_q == BSS_ST_HICCUP) ? hic_q + 32'h00000001 : 32'h00000000;
  end

  // Driver flops; both drop one cycle after readiness is lost
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
    end
    else
    begin
      hs_q <= hs_d;
      ls_q <= ls_d;
    end
  end

  // Gate bias select and soft-start done edge detector
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bias_q    <= 1'b1;
      ss_done_q <= 1'b0;
    end
    else
    begin
      bias_q    <= !light_load_i;
      ss_done_q <= ss_done_w;
    end
  end

  // Read data stands one cycle after the strobe and is zero otherwise
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_q <= 32'h00000000;
    else
      rdata_q <= re_i ? rd_mux_w : 32'h00000000;
  end

  // Ramp is held at zero outside readiness and during hiccup
  bss_ramp #(
    .PW       (PW)
  ) u_ramp (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .clr_i    (!por_q || state_q == BSS_ST_HICCUP || state_q == BSS_ST_OFF),
    .tick_i   (tick_w),
    .period_i (period_q),
    .ramp_o   (ramp_w),
    .done_o   ()
  );

  // Steps advance only once the first high-side pulse has been seen
  bss_prebias u_prebias (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .clr_i    (state_q != BSS_ST_PREBIAS && state_q != BSS_ST_RUN),
    .run_i    (state_q == BSS_ST_PREBIAS),
    .tick_i   (tick_w),
    .step_o   (step_w),
    .done_o   (pb_done_w)
  );

  assign high_side_switch_o = hs_q;
  assign low_side_switch_o  = ls_q;
  assign por_o              = por_q;
  assign bias_high_o        = bias_q;
  assign irq_o              = irq_q;
  assign rdata_o            = rdata_q;
  assign ss_ref_o           = ramp_w;
endmodule : bss_top

// file: rtl/bss_map.svh
// Offsets, field positions, reset values and timing counts of the buck start-up sequencer
`ifndef BSS_MAP_SVH
`define BSS_MAP_SVH

`define BSS_REG_CTRL        8'h00
`define BSS_REG_STATUS      8'h04
`define BSS_REG_INT_STAT    8'h08
`define BSS_REG_INT_MASK    8'h0C
`define BSS_REG_RAMP        8'h10
`define BSS_REG_PERIOD      8'h14

`define BSS_CTRL_RUN_BIT    0
`define BSS_CTRL_RESET      1'b1
`define BSS_MASK_RESET      5'h00

`define BSS_EV_POR          0
`define BSS_EV_LOCKOUT      1
`define BSS_EV_OC           2
`define BSS_EV_OV           3
`define BSS_EV_SS_DONE      4
`define BSS_EV_N            5

`define BSS_CLK_MHZ         50
`define BSS_SLOPE_UV_PER_US 400
`define BSS_RAMP_FINAL_UV   21'd1500000
`define BSS_START_LO_UV     21'd150000
`define BSS_START_HI_UV     21'd750000
`define BSS_TSTART_US       1500
`define BSS_HICCUP_US       20480
`define BSS_HICCUP_CYCLES   (`BSS_HICCUP_US * `BSS_CLK_MHZ)
`define BSS_PULSES_PER_STEP 16
`define BSS_DUTY_STEPS      8
`define BSS_FREQ_CODES      13

`endif

// file: rtl/bss_pkg.sv
// Types of the buck start-up sequencer
package bss_pkg;
  typedef enum logic [2:0] {
    BSS_ST_OFF     = 3'b000,
    BSS_ST_ASYNC   = 3'b001,
    BSS_ST_PREBIAS = 3'b010,
    BSS_ST_RUN     = 3'b011,
    BSS_ST_HICCUP  = 3'b100
  } bss_state_t;
endpackage : bss_pkg

// file: rtl/bss_ramp.sv
// Soft-start reference ramp counter in microvolts
`timescale 1ns/1ps
`include "bss_map.svh"
module bss_ramp
  import bss_pkg::*;
#(
  parameter int PW = 8
) (
  input  wire logic          mclk_i,   // Clock
  input  wire logic          rst_i,    // Async reset
  input  wire logic          clr_i,    // Hold ramp at zero
  input  wire logic          tick_i,   // Switching period tick
  input  wire logic [PW-1:0] period_i, // Period in clocks
  output logic      [20:0]   ramp_o,   // Reference in uV
  output logic               done_o    // Final level reached
);
  logic [20:0] ramp_d;
  logic [20:0] ramp_q;
  wire  [31:0] inc_w  = (32'(period_i) * `BSS_SLOPE_UV_PER_US) / `BSS_CLK_MHZ;
  wire  [21:0] sum_w  = {1'b0, ramp_q} + {1'b0, inc_w[20:0]};
  wire         full_w = (sum_w >= {1'b0, `BSS_RAMP_FINAL_UV});

  // Linear rise per tick, saturating at the final level
  always_comb
  begin
    ramp_d = ramp_q;
    if (clr_i)
      ramp_d = 21'h000000;
    else if (tick_i)
      ramp_d = full_w ? `BSS_RAMP_FINAL_UV : sum_w[20:0];
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      ramp_q <= 21'h000000;
    else
      ramp_q <= ramp_d;
  end

  assign ramp_o = ramp_q;
  assign done_o = (ramp_q == `BSS_RAMP_FINAL_UV);
endmodule : bss_ramp

// file: rtl/bss_prebias.sv
// Pre-bias duty stepper: eight steps of sixteen pulses each
`timescale 1ns/1ps
`include "bss_map.svh"
module bss_prebias
  import bss_pkg::*;
(
  input  wire logic       mclk_i,  // Clock
  input  wire logic       rst_i,   // Async reset
  input  wire logic       clr_i,   // Restart from step one
  input  wire logic       run_i,   // Stepping allowed
  input  wire logic       tick_i,  // Switching period tick
  output logic      [3:0] step_o,  // Duty in eighths, 1..8
  output logic            done_o   // All steps issued
);
  logic [3:0] step_q;
  logic [3:0] pulse_q;
  logic       done_q;
  wire        last_pulse_w = (pulse_q == 4'(`BSS_PULSES_PER_STEP - 1));
  wire        last_step_w  = (step_q == 4'(`BSS_DUTY_STEPS));

  // Sixteen periods per step, the last step too; holds full duty afterwards
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      step_q  <= 4'h1;
      pulse_q <= 4'h0;
      done_q  <= 1'b0;
    end
    else if (clr_i)
    begin
      step_q  <= 4'h1;
      pulse_q <= 4'h0;
      done_q  <= 1'b0;
    end
    else if (run_i && tick_i && !done_q)
    begin
      pulse_q <= last_pulse_w ? 4'h0 : pulse_q + 4'h1;
      if (last_pulse_w && last_step_w)
        done_q <= 1'b1;
      else if (last_pulse_w)
        step_q <= step_q + 4'h1;
    end
  end

  assign step_o = step_q;
  assign done_o = done_q;
endmodule : bss_prebias

// file: verif/bss_top_assertions.sv
// Port-level checker for the start-up sequencer
`timescale 1ns/1ps
module bss_top_assertions (
  input wire logic        mclk_i,             // Clock
  input wire logic        rst_i,              // Reset
  input wire logic        vcc_ok_i,           // Supply ok
  input wire logic        en_below_fall_i,    // Enable low
  input wire logic        en_above_rise_i,    // Enable high
  input wire logic        light_load_i,       // Light load
  input wire logic        ov_event_i,         // Overvoltage
  input wire logic        high_side_switch_o, // High driver
  input wire logic        low_side_switch_o,  // Low driver
  input wire logic        por_o,              // Ready
  input wire logic        bias_high_o,        // Bias select
  input wire logic [20:0] ss_ref_o            // Reference
);
  logic hs_seen_q;
  // High-side pulse seen since ready was last lost
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      hs_seen_q <= 1'b0;
    else if (!por_o && !low_side_switch_o)
      hs_seen_q <= 1'b0;
    else if (high_side_switch_o)
      hs_seen_q <= 1'b1;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  chk_supply_lockout: assert property (
    !vcc_ok_i |-> ##2 (!high_side_switch_o && !low_side_switch_o)) else $error("drivers on in lockout");
  chk_enable_shutdown: assert property (
    en_below_fall_i && !en_above_rise_i |-> ##3 (!high_side_switch_o && !low_side_switch_o))
    else $error("drivers on after shutdown");
  chk_ready_cause: assert property (
    $rose(por_o) |-> $past(vcc_ok_i) && !($past(en_below_fall_i, 2) && !$past(en_above_rise_i, 2)))
    else $error("ready without valid inputs");
  chk_low_side_first: assert property (
    !hs_seen_q && !high_side_switch_o |-> !low_side_switch_o) else $error("low side before high side");
  chk_ov_gate: assert property (
    ov_event_i |=> !high_side_switch_o) else $error("high side on in overvoltage");
  chk_bias_level: assert property (
    1'b1 |=> bias_high_o == !$past(light_load_i)) else $error("wrong bias level");
  chk_ramp_cleared: assert property (
    !por_o ##1 !por_o |=> ss_ref_o == 21'h0) else $error("ramp not cleared");
  chk_ramp_rises: assert property (
    $changed(ss_ref_o) && ss_ref_o != 21'h0 |-> ss_ref_o > $past(ss_ref_o) && ss_ref_o <= 21'h16E360)
    else $error("ramp not rising");
endmodule : bss_top_assertions

bind bss_top bss_top_assertions u_bss_top_assertions (.mclk_i, .rst_i, .vcc_ok_i, .en_below_fall_i,
  .en_above_rise_i, .light_load_i, .ov_event_i, .high_side_switch_o, .low_side_switch_o, .por_o,
  .bias_high_o, .ss_ref_o);

// file: verif/bss_far_side.sv
// Far side: supply and enable comparators, loop PWM requests
`timescale 1ns/1ps
module bss_far_side (
  input  wire logic        mclk_i,          // Clock
  input  wire logic        vcc_up_i,        // Supply up
  input  wire logic [11:0] en_mv_i,         // Enable, mV
  input  wire logic        pwm_on_i,        // Loop on
  input  wire logic [7:0]  per_i,           // Period
  output logic             vcc_ok_o,        // Supply ok
  output logic             en_above_rise_o, // Over 1.2V
  output logic             en_below_fall_o, // Under 1.0V
  output logic             hs_pwm_o,        // High request
  output logic             ls_pwm_o         // Low request
);
  logic [7:0] pos_q;
  // Thresholds; between them the device keeps its enable state
  assign vcc_ok_o        = vcc_up_i;
  assign en_above_rise_o = en_mv_i > 12'h4B0;
  assign en_below_fall_o = en_mv_i < 12'h3E8;
  // Short high-side request so the low side window is what limits duty
  assign hs_pwm_o = pwm_on_i && pos_q < 8'h04;
  assign ls_pwm_o = pwm_on_i && !hs_pwm_o;
  always_ff @(posedge mclk_i)
    pos_q <= (!pwm_on_i || pos_q >= per_i - 8'h01) ? 8'h00 : pos_q + 8'h01;
endmodule : bss_far_side

// file: verif/buck_startup_sequencer_bench.sv
// Self-checking bench for the start-up sequencer
`timescale 1ns/1ps
`include "bss_map.svh"
module buck_startup_sequencer_bench;
  localparam int P = 33;
  logic        mclk_i = 1'b0, rst_i = 1'b1, vcc_up = 1'b0, pwm_on = 1'b0, we_i = 1'b0, re_i = 1'b0;
  logic        light_load_i = 1'b0, oc_event_i = 1'b0, ov_event_i = 1'b0;
  logic [11:0] en_mv = 12'h000;
  logic [3:0]  freq_set_pin_i = 4'hC;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rd_v;
  logic [20:0] prev;
  wire         vcc_ok_i, en_above_rise_i, en_below_fall_i, hs_pwm_i, ls_pwm_i, irq_o, hs_o, ls_o, por_o;
  wire  [20:0] ss_ref_o;
  wire  [31:0] rdata_o;
  int          failures = 0, tests_run = 0, n, mx;
  // Clock and random load level
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) light_load_i <= 1'($urandom);
  bss_top #(.HICCUP_CYCLES(200), .PW(8)) u_bss_top (.mclk_i, .rst_i, .vcc_ok_i, .en_above_rise_i,
    .en_below_fall_i, .light_load_i, .oc_event_i, .ov_event_i, .hs_pwm_i, .ls_pwm_i, .freq_set_pin_i,
    .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .irq_o, .high_side_switch_o(hs_o), .low_side_switch_o(ls_o),
    .por_o, .bias_high_o(), .ss_ref_o);
  bss_far_side u_far (.mclk_i, .vcc_up_i(vcc_up), .en_mv_i(en_mv), .pwm_on_i(pwm_on), .per_i(8'(P)),
    .vcc_ok_o(vcc_ok_i), .en_above_rise_o(en_above_rise_i), .en_below_fall_o(en_below_fall_i),
    .hs_pwm_o(hs_pwm_i), .ls_pwm_o(ls_pwm_i));
  task automatic report_and_stop();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
      failures++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge mclk_i);
    we_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge mclk_i);
    re_i   <= 1'b0;
    #1 rd_v = rdata_o;
  endtask : rd
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask : cyc
  // Period in clocks for a resistor code at 50 MHz
  function automatic logic [31:0] per_of(input int c);
    return 32'(50000 / (300 + 100 * c));
  endfunction : per_of
  initial
  begin
    #1000000;
    failures++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(41367));
    cyc(8);
    rst_i <= 1'b0;
    rd(`BSS_REG_CTRL);
    chk("ctrl", 32'h1, rd_v);
    rd(8'h20);
    chk("unmapped", 32'h0, rd_v);
    for (int c = 0; c < 13; c++)
    begin
      freq_set_pin_i <= 4'(c);
      cyc(170); // New code is taken at the next wrap of the old period
      rd(`BSS_REG_PERIOD);
      chk("period", per_of(c), rd_v);
    end
    // Enable inside the hysteresis band must not start the part
    vcc_up <= 1'b1;
    en_mv  <= 12'h3E8 + 12'($urandom % 201);
    cyc(6);
    chk("por held", 32'h0, 32'(por_o));
    en_mv <= 12'h4B1;
    cyc(3);
    chk("por", 32'h1, 32'(por_o));
    en_mv <= 12'h3E8;
    cyc(4);
    chk("por hyst", 32'h1, 32'(por_o));
    rd(`BSS_REG_INT_STAT);
    chk("por event", 32'h1, 32'(rd_v[0]));
    wr(`BSS_REG_INT_MASK, 32'h1);
    cyc(2);
    chk("irq on", 32'h1, 32'(irq_o));
    wr(`BSS_REG_INT_STAT, 32'h1F);
    cyc(2);
    chk("irq off", 32'h0, 32'(irq_o));
    n = 0;
    while (ss_ref_o < 21'h249F0 && n < 30000)
    begin
      prev = ss_ref_o;
      cyc(1);
      n++;
      if (ss_ref_o != prev)
        chk("ramp step", 32'(8 * P), 32'(ss_ref_o - prev));
    end
    chk("ramp reach", 32'h1, 32'(n < 30000));
    rd(`BSS_REG_STATUS);
    chk("start window", 32'h1, 32'(rd_v[3]));
    chk("async", 32'h1, 32'(rd_v[6:4]));
    // First step: longest low-side pulse is one eighth of the period
    pwm_on <= 1'b1;
    mx = 0;
    n = 0;
    repeat (15 * P)
    begin
      cyc(1);
      n = ls_o ? n + 1 : 0;
      mx = n > mx ? n : mx;
    end
    chk("first duty", 32'h1, 32'(mx > 0 && mx <= (P + 7) / 8));
    n = 15 * P;
    do
    begin
      rd(`BSS_REG_STATUS);
      n += 2;
    end
    while (rd_v[6:4] != 3'h3 && n < 200 * P);
    chk("steps time", 32'h1, 32'(n >= 127 * P && n <= 131 * P));
    chk("last step", 32'h8, 32'(rd_v[11:8]));
    ov_event_i <= 1'b1;
    cyc(3);
    chk("masked irq", 32'h0, 32'(irq_o));
    ov_event_i <= 1'b0;
    rd(`BSS_REG_INT_STAT);
    chk("ov event", 32'h1, 32'(rd_v[3]));
    // Overcurrent: reference held at zero through the hiccup
    oc_event_i <= 1'b1;
    cyc(1);
    oc_event_i <= 1'b0;
    cyc(3);
    n = 0;
    repeat (180)
    begin
      cyc(1);
      n += 32'(ss_ref_o != 21'h0);
    end
    chk("hiccup ramp", 32'h0, 32'(n));
    rd(`BSS_REG_STATUS);
    chk("hiccup", 32'h4, 32'(rd_v[6:4]));
    n = 0;
    while (ss_ref_o == 21'h0 && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk("restart", 32'h1, 32'(n > 10 && n < 400));
    pwm_on <= 1'b0;
    vcc_up <= 1'b0;
    cyc(3);
    chk("lockout", 32'h0, 32'({por_o, hs_o, ls_o}));
    rd(`BSS_REG_INT_STAT);
    chk("lock event", 32'h1, 32'(rd_v[1]));
    vcc_up <= 1'b1;
    cyc(4);
    rd(`BSS_REG_STATUS);
    chk("relock", 32'h1, 32'(rd_v[6:4]));
    pwm_on <= 1'b1;
    cyc(2 * P);
    en_mv <= 12'h3E7;
    cyc(3);
    chk("shutdown", 32'h0, 32'({por_o, hs_o, ls_o}));
    report_and_stop();
  end
endmodule : buck_startup_sequencer_bench
